// [csw_defs.svh]
// Purpose: Offsets, field positions, reset values for the wake/offset register block
// Assumes: Register index times four gives the Wishbone byte address
// Notes: Definitions only
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH
// ==========================================
// Register indices
`define CSW_IDX_RES2H 6'h0b
`define CSW_IDX_AT1 6'h0c
`define CSW_IDX_RT1 6'h0d
`define CSW_IDX_AT2 6'h0e
`define CSW_IDX_RT2 6'h0f
`define CSW_IDX_OFS1 6'h10
`define CSW_IDX_OFS2 6'h11
`define CSW_IDX_DIV 6'h12
`define CSW_IDX_CTRL 6'h20
`define CSW_IDX_STAT 6'h21
`define CSW_IDX_MASK 6'h22
// ==========================================
// Fields and reset values
`define CSW_OFS_W 6
`define CSW_DIV_W 5
`define CSW_EVT_W 4
`define CSW_THR_RST 8'h00
`define CSW_OFS_RST 6'h00
`define CSW_DIV_RST 5'h01
`define CSW_CTRL_RST 4'h0
// Event bit positions, same in control, status and mask
`define CSW_BIT_ABS1 0
`define CSW_BIT_RATE1 1
`define CSW_BIT_ABS2 2
`define CSW_BIT_RATE2 3
`endif

// [csw_pkg.sv]
// Purpose: Types and shared arithmetic for the wake/offset register block
// Assumes: 12-bit conversion results, 8-bit stored thresholds
// Notes: Constants live in csw_defs.svh
package csw_pkg;
   typedef logic [11:0] csw_res_t;
   typedef logic [7:0] csw_byte_t;
   typedef enum logic [1:0] {
      CSW_IDLE = 2'b01,
      CSW_ACK = 2'b10
   } csw_bus_state_t;
   // Stored upper bits widened with zero low nibble
   function automatic csw_res_t csw_thr12(input csw_byte_t thr);
      csw_thr12 = {thr, 4'h0};
   endfunction
endpackage

// [csw_std_div.sv]
// Purpose: Conversion-rate divider, active only in standby
// Assumes: slot_i pulses once per possible conversion
// Notes: Divider value 0 acts as 1
`timescale 1ns/1ps
module csw_std_div #(
   parameter int DIV_W = 5
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic slot_i,
   input wire logic standby_i,
   input wire logic [DIV_W-1:0] div_i,
   // Request
   output logic req_o
);
   logic [DIV_W-1:0] cnt_q;
   generate
      if (DIV_W < 1 || DIV_W > 8) begin : g_bad
         $error("csw_std_div: DIV_W out of range");
      end
   endgenerate
   // ==========================================
   // Slot counting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         req_o <= 1'b0;
      end else if (!standby_i) begin
         cnt_q <= '0;
         req_o <= slot_i;
      end else if (slot_i) begin
         // Keep full rate when divider is 0 or 1
         if (cnt_q + DIV_W'(1) >= div_i) begin
            cnt_q <= '0;
            req_o <= 1'b1;
         end else begin
            cnt_q <= cnt_q + DIV_W'(1);
            req_o <= 1'b0;
         end
      end else begin
         req_o <= 1'b0;
      end
   end
endmodule

// [csw_wake_det.sv]
// Purpose: Absolute and rate-of-change wake detection for one channel
// Assumes: done_i pulses once per finished conversion
// Notes: Rate is the change between two successive results
`timescale 1ns/1ps
module csw_wake_det
   import csw_pkg::*;
#(
   parameter int RES_W = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Conversion
   input wire logic done_i,
   input wire csw_pkg::csw_res_t result_i,
   input wire logic standby_i,
   // Configuration
   input wire logic abs_en_i,
   input wire logic rate_en_i,
   input wire csw_pkg::csw_byte_t abs_thr_i,
   input wire csw_pkg::csw_byte_t rate_thr_i,
   // Events
   output logic abs_evt_o,
   output logic rate_evt_o
);
   csw_res_t prev_q;
   logic prev_vld_q;
   csw_res_t delta;
   generate
      if (RES_W != 12) begin : g_bad
         $error("csw_wake_det: only 12-bit results supported");
      end
   endgenerate
   assign delta = (result_i > prev_q) ? result_i - prev_q : prev_q - result_i;
   // ==========================================
   // History
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= '0;
         prev_vld_q <= 1'b0;
      end else if (done_i) begin
         prev_q <= result_i;
         prev_vld_q <= 1'b1;
      end
   end
   // ==========================================
   // Events, only in standby
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         abs_evt_o <= 1'b0;
         rate_evt_o <= 1'b0;
      end else begin
         // Threshold ignored entirely while disabled
         abs_evt_o <= done_i && standby_i && abs_en_i && (result_i >= csw_thr12(abs_thr_i));
         rate_evt_o <= done_i && standby_i && rate_en_i && prev_vld_q
                       && (delta >= csw_thr12(rate_thr_i));
      end
   end
   // ==========================================
   // Checks
   AST_ABS_FIRE: assert property (@(posedge clk_i) disable iff (rst_i)
      done_i && standby_i && abs_en_i && result_i >= {abs_thr_i, 4'h0} |=> abs_evt_o)
      else $error("absolute wake missed");
   AST_ABS_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      !abs_en_i || !standby_i |=> !abs_evt_o)
      else $error("absolute wake while disabled");
   AST_ABS_BELOW: assert property (@(posedge clk_i) disable iff (rst_i)
      result_i < {abs_thr_i, 4'h0} |=> !abs_evt_o)
      else $error("absolute wake below threshold");
   AST_RATE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      !rate_en_i |=> !rate_evt_o)
      else $error("rate wake while disabled");
   AST_RATE_FIRE: assert property (@(posedge clk_i) disable iff (rst_i)
      done_i && standby_i && rate_en_i && prev_vld_q && delta >= {rate_thr_i, 4'h0} |=> rate_evt_o)
      else $error("rate wake missed");
   COV_RATE: cover property (@(posedge clk_i) disable iff (rst_i) rate_evt_o);
endmodule

// [csw_regs.sv]
// Purpose: Wake threshold, capacitance offset and standby divider registers on Wishbone
// Assumes: Classic Wishbone, 32-bit data, byte address = register index * 4
// Notes: Registers sit in the low byte lane; upper bits read zero
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "csw_defs.svh"
module csw_regs (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Front end conversions
   input wire logic ch1_done_i,
   input wire csw_pkg::csw_res_t ch1_result_i,
   input wire logic ch2_done_i,
   input wire csw_pkg::csw_res_t ch2_result_i,
   input wire logic slot_i,
   input wire logic standby_i,
   // Front end control
   output logic conv_req_o,
   output logic [5:0] ch1_offset_o,
   output logic [5:0] ch2_offset_o,
   // Interrupt
   output logic irq_o
);
   import csw_pkg::*;

   csw_bus_state_t bus_q;
   csw_byte_t res2h_q;
   csw_byte_t at1_q;
   csw_byte_t rt1_q;
   csw_byte_t at2_q;
   csw_byte_t rt2_q;
   logic [`CSW_OFS_W-1:0] ofs1_q;
   logic [`CSW_OFS_W-1:0] ofs2_q;
   logic [`CSW_DIV_W-1:0] div_q;
   logic [`CSW_EVT_W-1:0] ctrl_q;
   logic [`CSW_EVT_W-1:0] stat_q;
   logic [`CSW_EVT_W-1:0] mask_q;
   logic [`CSW_EVT_W-1:0] evt;
   logic [5:0] idx;
   logic req;
   logic wr;
   csw_byte_t wbyte;
   csw_byte_t rbyte;

   // ==========================================
   // Bus decode
   assign idx = wb_adr_i[7:2];
   assign req = wb_cyc_i && wb_stb_i && (bus_q == CSW_IDLE);
   // Only the low lane carries register data
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];

   always_comb begin
      case (idx)
         `CSW_IDX_RES2H: rbyte = res2h_q;
         `CSW_IDX_AT1: rbyte = at1_q;
         `CSW_IDX_RT1: rbyte = rt1_q;
         `CSW_IDX_AT2: rbyte = at2_q;
         `CSW_IDX_RT2: rbyte = rt2_q;
         `CSW_IDX_OFS1: rbyte = {2'h0, ofs1_q};
         `CSW_IDX_OFS2: rbyte = {2'h0, ofs2_q};
         `CSW_IDX_DIV: rbyte = {3'h0, div_q};
         `CSW_IDX_CTRL: rbyte = {4'h0, ctrl_q};
         `CSW_IDX_STAT: rbyte = {4'h0, stat_q};
         `CSW_IDX_MASK: rbyte = {4'h0, mask_q};
         default: rbyte = 8'h00;
      endcase
   end

   // ==========================================
   // Handshake: ack one cycle after request, dropped next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_q <= CSW_IDLE;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         case (bus_q)
            CSW_IDLE: begin
               if (req) begin
                  bus_q <= CSW_ACK;
                  wb_ack_o <= 1'b1;
                  wb_dat_o <= {24'h00_0000, rbyte};
               end
            end
            CSW_ACK: begin
               bus_q <= CSW_IDLE;
               wb_ack_o <= 1'b0;
            end
            default: begin
               bus_q <= CSW_IDLE;
               wb_ack_o <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================
   // Result capture, not writable from the bus
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res2h_q <= 8'h00;
      end else if (ch2_done_i) begin
         res2h_q <= ch2_result_i[11:4];
      end
   end

   // ==========================================
   // Threshold registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         at1_q <= `CSW_THR_RST;
         rt1_q <= `CSW_THR_RST;
         at2_q <= `CSW_THR_RST;
         rt2_q <= `CSW_THR_RST;
      end else if (wr) begin
         if (idx == `CSW_IDX_AT1) at1_q <= wbyte;
         if (idx == `CSW_IDX_RT1) rt1_q <= wbyte;
         if (idx == `CSW_IDX_AT2) at2_q <= wbyte;
         if (idx == `CSW_IDX_RT2) rt2_q <= wbyte;
      end
   end

   // ==========================================
   // Offset and divider registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ofs1_q <= `CSW_OFS_RST;
         ofs2_q <= `CSW_OFS_RST;
         div_q <= `CSW_DIV_RST;
      end else if (wr) begin
         if (idx == `CSW_IDX_OFS1) ofs1_q <= wbyte[5:0];
         if (idx == `CSW_IDX_OFS2) ofs2_q <= wbyte[5:0];
         if (idx == `CSW_IDX_DIV) div_q <= wbyte[4:0];
      end
   end

   // ==========================================
   // Detection enables and interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `CSW_CTRL_RST;
         mask_q <= `CSW_CTRL_RST;
      end else if (wr) begin
         if (idx == `CSW_IDX_CTRL) ctrl_q <= wbyte[3:0];
         if (idx == `CSW_IDX_MASK) mask_q <= wbyte[3:0];
      end
   end

   // ==========================================
   // Sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= `CSW_CTRL_RST;
      end else if (wr && idx == `CSW_IDX_STAT) begin
         stat_q <= (stat_q & ~wbyte[3:0]) | evt;
      end else begin
         stat_q <= stat_q | evt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(stat_q & mask_q);
      end
   end

   // ==========================================
   // Wake detectors
   csw_wake_det #(.RES_W(12)) u_det1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .done_i(ch1_done_i),
      .result_i(ch1_result_i),
      .standby_i(standby_i),
      .abs_en_i(ctrl_q[`CSW_BIT_ABS1]),
      .rate_en_i(ctrl_q[`CSW_BIT_RATE1]),
      .abs_thr_i(at1_q),
      .rate_thr_i(rt1_q),
      .abs_evt_o(evt[`CSW_BIT_ABS1]),
      .rate_evt_o(evt[`CSW_BIT_RATE1])
   );

   csw_wake_det #(.RES_W(12)) u_det2 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .done_i(ch2_done_i),
      .result_i(ch2_result_i),
      .standby_i(standby_i),
      .abs_en_i(ctrl_q[`CSW_BIT_ABS2]),
      .rate_en_i(ctrl_q[`CSW_BIT_RATE2]),
      .abs_thr_i(at2_q),
      .rate_thr_i(rt2_q),
      .abs_evt_o(evt[`CSW_BIT_ABS2]),
      .rate_evt_o(evt[`CSW_BIT_RATE2])
   );

   // ==========================================
   // Conversion pacing and offset hand-off
   csw_std_div #(.DIV_W(`CSW_DIV_W)) u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .slot_i(slot_i),
      .standby_i(standby_i),
      .div_i(div_q),
      .req_o(conv_req_o)
   );

   // Offsets only move at a conversion start, so a running one keeps its setting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ch1_offset_o <= `CSW_OFS_RST;
         ch2_offset_o <= `CSW_OFS_RST;
      end else if (conv_req_o) begin
         ch1_offset_o <= ofs1_q;
         ch2_offset_o <= ofs2_q;
      end
   end

   // ==========================================
   // Checks
   AST_RES_RO: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == `CSW_IDX_RES2H && !ch2_done_i |=> res2h_q == $past(res2h_q))
      else $error("result byte changed by write");
   AST_RES_CAP: assert property (@(posedge clk_i) disable iff (rst_i)
      ch2_done_i |=> res2h_q == $past(ch2_result_i[11:4]))
      else $error("result byte not captured");
   AST_THR_RST: assert property (@(posedge clk_i)
      rst_i |=> at1_q == 8'h00 && rt1_q == 8'h00 && at2_q == 8'h00 && rt2_q == 8'h00)
      else $error("threshold not cleared");
   AST_THR_WR: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == `CSW_IDX_RT2 |=> wb_ack_o && rt2_q == $past(wbyte))
      else $error("threshold write lost");
   AST_CO_WR: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == `CSW_IDX_OFS1 |=> ofs1_q == $past(wb_dat_i[5:0]))
      else $error("offset write lost");
   AST_CO_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(idx) inside {`CSW_IDX_OFS1, `CSW_IDX_OFS2} |-> wb_dat_o[31:6] == 26'h0)
      else $error("offset reserved bits nonzero");
   AST_CO_RST: assert property (@(posedge clk_i)
      rst_i |=> ofs1_q == 6'h00 && ofs2_q == 6'h00 && ch1_offset_o == 6'h00 && ch2_offset_o == 6'h00)
      else $error("offset not cleared");
   AST_DIV_RST: assert property (@(posedge clk_i)
      rst_i |=> div_q == 5'h01)
      else $error("divider reset value wrong");
   AST_DIV_WR: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == `CSW_IDX_DIV |=> div_q == $past(wbyte[4:0]))
      else $error("divider write lost");
   AST_RES_RST: assert property (@(posedge clk_i)
      rst_i |=> res2h_q == 8'h00)
      else $error("result byte not cleared");
   AST_OFS_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      conv_req_o |=> ch1_offset_o == $past(ofs1_q) && ch2_offset_o == $past(ofs2_q))
      else $error("offset not applied at conversion start");
   // Status must keep every event, even against a clear
   AST_STAT_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      (|evt) |=> (stat_q & $past(evt)) == $past(evt))
      else $error("wake event lost in status");
   AST_STAT_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == `CSW_IDX_STAT && evt == 4'h0 |=> stat_q == ($past(stat_q) & ~$past(wbyte[3:0])))
      else $error("status clear wrong");
   AST_IRQ_LVL: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> irq_o == |($past(stat_q) & $past(mask_q)))
      else $error("interrupt level wrong");
   // Bus answer timing, upper read lanes and offset hold
   AST_ACK_ANS: assert property (@(posedge clk_i) disable iff (rst_i)
      req |=> wb_ack_o)
      else $error("request not acknowledged");
   AST_RD_HI: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read lanes nonzero");
   AST_OFS_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      !conv_req_o |=> $stable(ch1_offset_o) && $stable(ch2_offset_o))
      else $error("offset moved mid conversion");
   AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   COV_WAKE_IRQ: cover property (@(posedge clk_i) disable iff (rst_i) |evt ##[1:3] irq_o);
   COV_STDBY_REQ: cover property (@(posedge clk_i) disable iff (rst_i) standby_i && conv_req_o);
   COV_OFS_APPLY: cover property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == `CSW_IDX_OFS2 ##[1:20] conv_req_o);
endmodule

// [csw_fe_model.sv]
// Purpose: Front-end model answering conversion requests with bench-chosen results
// Assumes: One conversion per req_i pulse, both channels together
// Notes: Results off the done cycle show the inverse, never a stale match
`timescale 1ns/1ps
module csw_fe_model #(
   parameter int LAT = 3
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Request and chosen results
   input wire logic req_i,
   input wire logic [11:0] r1_i,
   input wire logic [11:0] r2_i,
   // Conversion outputs
   output logic done1_o,
   output logic done2_o,
   output logic [11:0] res1_o,
   output logic [11:0] res2_o
);
   int cnt_q;
   // ==========================================
   // Conversion latency
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 0;
      end else if (req_i) begin
         cnt_q <= LAT;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
      end
   end
   assign done1_o = (cnt_q == 1);
   assign done2_o = (cnt_q == 1);
   assign res1_o = done1_o ? r1_i : ~r1_i;
   assign res2_o = done2_o ? r2_i : ~r2_i;
endmodule

// [cap_sense_wakeup_offset_regs_tb_top.sv]
// Purpose: Self-checking bench for the wake/offset register block
// Assumes: Read data is checked by a monitor against a queue of expectations
// Notes: Offsets and irq level are compared directly at the ports
`timescale 1ns/1ps
`include "csw_defs.svh"
module cap_sense_wakeup_offset_regs_tb_top;
   import csw_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, slot_i = 1'b0, standby_i = 1'b0, conv_req_o, irq_o;
   logic ch1_done, ch2_done;
   logic [11:0] ch1_res, ch2_res, fe_r1 = 12'h0, fe_r2 = 12'h0;
   logic [5:0] ch1_offset_o, ch2_offset_o;
   logic [31:0] seed = 32'h2d47;
   logic [31:0] exp_q[$];
   int errors = 0, samples_checked = 0, req_cnt = 0;
   always #5 clk_i = ~clk_i;
   // ==========================================
   // Design and front end
   csw_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ch1_done_i(ch1_done), .ch1_result_i(ch1_res),
      .ch2_done_i(ch2_done), .ch2_result_i(ch2_res), .slot_i(slot_i), .standby_i(standby_i),
      .conv_req_o(conv_req_o), .ch1_offset_o(ch1_offset_o), .ch2_offset_o(ch2_offset_o),
      .irq_o(irq_o));
   csw_fe_model #(.LAT(3)) fe (.clk_i(clk_i), .rst_i(rst_i), .req_i(conv_req_o), .r1_i(fe_r1),
      .r2_i(fe_r2), .done1_o(ch1_done), .done2_o(ch2_done), .res1_o(ch1_res), .res2_o(ch2_res));
   // ==========================================
   // Helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      samples_checked++;
      if (seen !== expv) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
      end
   endtask
   task automatic print_verdict();
      if (exp_q.size() != 0) errors++;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Classic single cycle; upper data bits random since only the low lane counts
   task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d, input logic [7:0] e);
      int n;
      logic [31:0] r;
      n = 0;
      r = xs();
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, r[1:0]};
      wb_sel_i <= {r[3:1], 1'b1};
      wb_dat_i <= {r[31:8], d};
      if (!we) exp_q.push_back({24'h0, e});
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) errors++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic convert(input logic [11:0] a, input logic [11:0] b);
      int n;
      n = 0;
      fe_r1 <= a;
      fe_r2 <= b;
      @(posedge clk_i);
      slot_i <= 1'b1;
      @(posedge clk_i);
      slot_i <= 1'b0;
      while (ch2_done !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      repeat (5) @(posedge clk_i);
   endtask
   // ==========================================
   // Monitor and request counter
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, wb_dat_o, 32'h0);
         end else begin
            chk(wb_dat_o, exp_q.pop_front());
         end
      end
      if (conv_req_o === 1'b1) req_cnt++;
   end
   initial begin
      #100us;
      errors++;
      print_verdict();
   end
   // ==========================================
   // Scenarios
   initial begin
      logic [31:0] v;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = `CSW_IDX_RES2H; i <= `CSW_IDX_DIV; i++) begin
         wb(1'b0, 6'(i), 8'h00, (i == `CSW_IDX_DIV) ? 8'h01 : 8'h00);
      end
      wb(1'b0, 6'h30, 8'h00, 8'h00);
      for (int i = `CSW_IDX_AT1; i <= `CSW_IDX_RT2; i++) begin
         v = xs();
         wb(1'b1, 6'(i), v[7:0], 8'h00);
         wb(1'b0, 6'(i), 8'h00, v[7:0]);
      end
      wb(1'b1, `CSW_IDX_OFS1, 8'hff, 8'h00);
      wb(1'b1, `CSW_IDX_OFS2, 8'h2a, 8'h00);
      wb(1'b0, `CSW_IDX_OFS1, 8'h00, 8'h3f);
      wb(1'b0, `CSW_IDX_OFS2, 8'h00, 8'h2a);
      chk({26'h0, ch1_offset_o}, 32'h0);
      convert(12'h123, 12'hab7);
      chk({26'h0, ch1_offset_o}, 32'h3f);
      chk({26'h0, ch2_offset_o}, 32'h2a);
      wb(1'b1, `CSW_IDX_RES2H, 8'h00, 8'h00);
      wb(1'b0, `CSW_IDX_RES2H, 8'h00, 8'hab);
      // Wake detection in standby, exact boundaries
      standby_i <= 1'b1;
      wb(1'b1, `CSW_IDX_AT1, 8'h40, 8'h00);
      wb(1'b1, `CSW_IDX_RT1, 8'h20, 8'h00);
      wb(1'b1, `CSW_IDX_AT2, 8'h80, 8'h00);
      wb(1'b1, `CSW_IDX_RT2, 8'hff, 8'h00);
      wb(1'b1, `CSW_IDX_MASK, 8'h0f, 8'h00);
      wb(1'b1, `CSW_IDX_CTRL, 8'h00, 8'h00);
      convert(12'h400, 12'h000);
      wb(1'b0, `CSW_IDX_STAT, 8'h00, 8'h00);
      wb(1'b1, `CSW_IDX_CTRL, 8'h0f, 8'h00);
      convert(12'h3ff, 12'h7ff);
      wb(1'b0, `CSW_IDX_STAT, 8'h00, 8'h00);
      chk({31'h0, irq_o}, 32'h0);
      convert(12'h400, 12'h800);
      wb(1'b0, `CSW_IDX_STAT, 8'h00, 8'h05);
      chk({31'h0, irq_o}, 32'h1);
      wb(1'b1, `CSW_IDX_MASK, 8'h00, 8'h00);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      wb(1'b1, `CSW_IDX_STAT, 8'h05, 8'h00);
      convert(12'h200, 12'h800);
      wb(1'b0, `CSW_IDX_STAT, 8'h00, 8'h06);
      wb(1'b1, `CSW_IDX_MASK, 8'h02, 8'h00);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h1);
      wb(1'b1, `CSW_IDX_STAT, 8'h0f, 8'h00);
      // Channel 2 rate wake with a small threshold
      wb(1'b1, `CSW_IDX_RT2, 8'h08, 8'h00);
      convert(12'h200, 12'h700);
      wb(1'b0, `CSW_IDX_STAT, 8'h00, 8'h08);
      chk({31'h0, irq_o}, 32'h0);
      wb(1'b1, `CSW_IDX_STAT, 8'h0f, 8'h00);
      wb(1'b1, `CSW_IDX_CTRL, 8'h00, 8'h00);
      // Standby divider slows conversion requests
      wb(1'b1, `CSW_IDX_DIV, 8'hff, 8'h00);
      wb(1'b0, `CSW_IDX_DIV, 8'h00, 8'h1f);
      wb(1'b1, `CSW_IDX_DIV, 8'h03, 8'h00);
      req_cnt = 0;
      repeat (6) convert(12'h000, 12'h000);
      chk(req_cnt, 32'h2);
      wb(1'b0, `CSW_IDX_STAT, 8'h00, 8'h00);
      standby_i <= 1'b0;
      wb(1'b1, `CSW_IDX_CTRL, 8'h0f, 8'h00);
      convert(12'hfff, 12'hfff);
      wb(1'b0, `CSW_IDX_STAT, 8'h00, 8'h00);
      // Second reset in mid-run must restore the result, threshold, offset and divider defaults
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({26'h0, ch1_offset_o}, 32'h0);
      chk({26'h0, ch2_offset_o}, 32'h0);
      wb(1'b0, `CSW_IDX_RES2H, 8'h00, 8'h00);
      for (int i = `CSW_IDX_AT1; i <= `CSW_IDX_DIV; i++) begin
         wb(1'b0, 6'(i), 8'h00, (i == `CSW_IDX_DIV) ? 8'h01 : 8'h00);
      end
      repeat (4) @(posedge clk_i);
      print_verdict();
   end
endmodule
